// file: rtl/npt_pkg.sv
// Shared constants, types and helpers for the address and port translator.
// Assumes a single 100 MHz system clock and synchronous packet header streams.
`default_nettype none

package npt_pkg;

   // ----------------------------------------------------------------
   // Timing constants
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned AGE_TICK_S = 1;
   localparam int unsigned AGE_TICK_CYC = CLK_FREQ_HZ * AGE_TICK_S;
   localparam logic [15:0] TMO_DEF_SEC = 16'h012C; // 300 seconds.

   // ----------------------------------------------------------------
   // Table and address constants
   // ----------------------------------------------------------------
   localparam int unsigned TBL_DEPTH_DEF = 16;
   localparam logic [15:0] PUB_PORT_BASE = 16'hC000;
   localparam logic [31:0] PRIV_A_NET = 32'h0A000000;
   localparam logic [31:0] PRIV_A_MSK = 32'hFF000000;
   localparam logic [31:0] PRIV_B_NET = 32'hAC100000;
   localparam logic [31:0] PRIV_B_MSK = 32'hFFF00000;
   localparam logic [31:0] PRIV_C_NET = 32'hC0A80000;
   localparam logic [31:0] PRIV_C_MSK = 32'hFFFF0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {PR_OTHER, PR_TCP, PR_UDP, PR_ICMP, PR_IGMP} npt_proto_e;
   typedef enum logic [1:0] {ACT_FWD_OPER, ACT_FWD_CUST, ACT_LOCAL, ACT_DROP} npt_act_e;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_MAIN = 2'h1,
      ST_ALG = 2'h3,
      ST_SEND = 2'h2
   } npt_state_e;

   typedef struct packed {
      logic [31:0] ip;
      logic [15:0] port;
   } npt_ap_s;

   typedef struct packed {
      logic from_oper;
      npt_proto_e proto;
      npt_ap_s src;
      npt_ap_s dst;
      logic icmp_err;
      npt_ap_s in_src;
      npt_ap_s in_dst;
      logic ftp_sig;
      npt_ap_s ftp;
      logic tcp_close;
   } npt_hdr_s;

   typedef struct packed {
      npt_act_e act;
      npt_hdr_s hdr;
   } npt_out_s;

   // Tells whether an address lies in one of the reserved private ranges.
   function automatic logic npt_is_private(input logic [31:0] ip);
      npt_is_private = ((ip & PRIV_A_MSK) == PRIV_A_NET) ||
                       ((ip & PRIV_B_MSK) == PRIV_B_NET) ||
                       ((ip & PRIV_C_MSK) == PRIV_C_NET);
   endfunction

endpackage

`default_nettype wire

// file: rtl/npt_match.sv
// Private pair lookup over all table entries, plus first free entry.
// Assumes the entry array and key are stable within the cycle.
`default_nettype none

module npt_match #(
   parameter int unsigned N = 16,
   parameter int unsigned IW = 4
) (
   input wire logic [N-1:0] vld, // Entry valid bits.
   input wire npt_pkg::npt_ap_s [N-1:0] ent, // Private pair per entry.
   input wire npt_pkg::npt_ap_s key, // Private pair looked up.
   output logic hit, // Key found.
   output logic [IW-1:0] hit_idx, // Entry holding the key.
   output logic free_ok, // A free entry exists.
   output logic [IW-1:0] free_idx // Lowest free entry.
);
   import npt_pkg::*;

   logic [N-1:0] eq;

   // ----------------------------------------------------------------
   // Per-entry compare
   // ----------------------------------------------------------------
   // Only the private pair is compared, never the destination.
   for (genvar g = 0; g < N; g++) begin : g_cmp
      assign eq[g] = vld[g] && (ent[g] == key);
   end

   // Priority encoders pick the lowest matching and lowest free entry.
   always_comb
   begin
      hit = 1'b0;
      hit_idx = '0;
      free_ok = 1'b0;
      free_idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (eq[i])
         begin
            hit = 1'b1;
            hit_idx = IW'(i);
         end
         if (!vld[i])
         begin
            free_ok = 1'b1;
            free_idx = IW'(i);
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/npt_age.sv
// Per-entry age counters driven by a one second tick.
// Assumes restart pulses come from the translator on each use of an entry.
`default_nettype none

module npt_age #(
   parameter int unsigned N = 16,
   parameter int unsigned TICK_CYC = 100,
   parameter int unsigned TW = 16
) (
   input wire logic sys_clk, // System clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic [N-1:0] restart, // Restart pulse per entry.
   input wire logic [TW-1:0] timeout, // Timeout in seconds.
   output logic [N-1:0] expired // Entry age reached the timeout.
);
   import npt_pkg::*;

   localparam int unsigned PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

   logic [PW-1:0] pre_ff;
   logic tick;

   // ----------------------------------------------------------------
   // Seconds prescaler
   // ----------------------------------------------------------------
   assign tick = (pre_ff == PW'(TICK_CYC - 1));

   // Counts system cycles to one second.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         pre_ff <= '0;
      else
         pre_ff <= tick ? '0 : pre_ff + 1'b1;
   end

   // ----------------------------------------------------------------
   // Age counters
   // ----------------------------------------------------------------
   for (genvar g = 0; g < N; g++) begin : g_age
      logic [TW-1:0] age_ff;

      // A use restarts the age; otherwise it climbs once a second until it reaches the timeout.
      always_ff @(posedge sys_clk or negedge rstn)
      begin
         if (!rstn)
            age_ff <= '0;
         else if (restart[g])
            age_ff <= '0;
         else if (tick && (age_ff < timeout))
            age_ff <= age_ff + 1'b1;
      end

      assign expired[g] = (age_ff >= timeout) && !restart[g];

      restart_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
         restart[g] |=> (age_ff == '0))
         else $error("age not restarted on use");

      age_expire_a: assert property (@(posedge sys_clk) disable iff (!rstn)
         (tick && !restart[g] && (age_ff + 1'b1 == timeout) && (timeout != '0))
         ##1 !restart[g] |-> expired[g])
         else $error("entry did not expire at timeout");
   end

endmodule

`default_nettype wire

// file: rtl/npt_translator.sv
// Address and port translation stage between customer and operator sides.
// Assumes one header descriptor per packet on a valid/ready stream; the
// payload travels elsewhere and is rewritten from the returned descriptor.
`default_nettype none

module npt_translator #(
   parameter int unsigned TBL_DEPTH = npt_pkg::TBL_DEPTH_DEF,
   parameter int unsigned AGE_TICK_CYC = npt_pkg::AGE_TICK_CYC,
   parameter int unsigned TMO_W = 16
) (
   input wire logic sys_clk, // System clock, 100 MHz.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic in_valid, // Header offered.
   output logic in_ready, // Header taken when high with in_valid.
   input wire npt_pkg::npt_hdr_s in_hdr, // Incoming header descriptor.
   output logic out_valid, // Result offered.
   input wire logic out_ready, // Result taken when high with out_valid.
   output npt_pkg::npt_out_s out_pkt, // Rewritten header and action.
   input wire logic [31:0] cfg_pub_ip, // Operator-side public address.
   input wire logic [31:0] cfg_cust_ip, // Customer-side own address.
   input wire logic cfg_tmo_en, // Use cfg_tmo_sec instead of default.
   input wire logic [TMO_W-1:0] cfg_tmo_sec, // Configured timeout, seconds.
   output logic cfg_bad, // Customer-side address is not private.
   output logic tbl_full // Every entry in use.
);
   import npt_pkg::*;

   localparam int unsigned IW = $clog2(TBL_DEPTH);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (TBL_DEPTH < 2 || TBL_DEPTH > 1024 || AGE_TICK_CYC < 2 || TMO_W < 9) begin : g_chk
      $error("npt_translator: unsupported parameter values");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   npt_state_e st_ff;
   npt_state_e nxt_st;
   npt_hdr_s hdr_ff;
   npt_out_s pkt_ff;
   npt_out_s nxt_pkt;
   logic in_ready_ff;
   logic out_valid_ff;
   logic cfg_bad_ff;
   logic tbl_full_ff;
   logic [TBL_DEPTH-1:0] ent_vld_ff;
   npt_ap_s [TBL_DEPTH-1:0] ent_ff;

   // Lookup and update signals.
   npt_ap_s key;
   logic ob_hit;
   logic [IW-1:0] ob_hit_idx;
   logic ob_free_ok;
   logic [IW-1:0] ob_free_idx;
   logic [15:0] ib_port;
   logic [15:0] ib_off;
   logic [IW-1:0] ib_idx;
   logic ib_hit;
   logic wr_en;
   logic use_en;
   logic close_en;
   logic [IW-1:0] use_idx;
   logic [15:0] use_port;
   logic [TBL_DEPTH-1:0] restart;
   logic [TBL_DEPTH-1:0] expired;
   logic [TMO_W-1:0] tmo_sec;
   logic src_priv;
   logic dst_priv;
   logic is_igmp;

   assign in_ready = in_ready_ff;
   assign out_valid = out_valid_ff;
   assign out_pkt = pkt_ff;
   assign cfg_bad = cfg_bad_ff;
   assign tbl_full = tbl_full_ff;

   // ----------------------------------------------------------------
   // Lookups
   // ----------------------------------------------------------------
   // Outbound key is the private pair; an ICMP error is keyed on the pair
   // that the embedded header carries as its destination.
   always_comb
   begin
      if (st_ff == ST_ALG)
         key = hdr_ff.ftp;
      else if (hdr_ff.icmp_err)
         key = hdr_ff.in_dst;
      else
         key = hdr_ff.src;
   end

   npt_match #(
      .N(TBL_DEPTH),
      .IW(IW)
   ) u_match (
      .vld(ent_vld_ff),
      .ent(ent_ff),
      .key(key),
      .hit(ob_hit),
      .hit_idx(ob_hit_idx),
      .free_ok(ob_free_ok),
      .free_idx(ob_free_idx)
   );

   // Inbound public port indexes the table directly, so the reverse
   // mapping exists the moment the forward one is written.
   assign ib_port = hdr_ff.icmp_err ? hdr_ff.in_src.port : hdr_ff.dst.port;
   assign ib_off = ib_port - PUB_PORT_BASE;
   assign ib_idx = ib_off[IW-1:0];
   assign ib_hit = (hdr_ff.dst.ip == cfg_pub_ip) && (ib_port >= PUB_PORT_BASE) &&
                   (ib_off < 16'(TBL_DEPTH)) && ent_vld_ff[ib_idx];

   assign src_priv = npt_is_private(hdr_ff.src.ip);
   assign dst_priv = npt_is_private(hdr_ff.dst.ip);
   assign is_igmp = (hdr_ff.proto == PR_IGMP);
   assign tmo_sec = cfg_tmo_en ? cfg_tmo_sec : TMO_W'(TMO_DEF_SEC);

   // ----------------------------------------------------------------
   // Translation decision
   // ----------------------------------------------------------------
   // Chooses the action, rewrites the header and names the entry touched.
   always_comb
   begin
      nxt_pkt = pkt_ff;
      nxt_st = st_ff;
      wr_en = 1'b0;
      use_en = 1'b0;
      close_en = 1'b0;
      use_idx = '0;
      case (st_ff)
         ST_IDLE:
         begin
            if (in_valid && in_ready_ff)
               nxt_st = ST_MAIN;
         end
         ST_MAIN:
         begin
            nxt_pkt.hdr = hdr_ff;
            nxt_pkt.act = ACT_DROP;
            nxt_st = ST_SEND;
            if (is_igmp)
               nxt_pkt.act = ACT_LOCAL;
            else if (!hdr_ff.from_oper)
            begin
               if (!src_priv)
                  nxt_pkt.act = ACT_DROP;
               else if (dst_priv)
                  nxt_pkt.act = ACT_FWD_CUST;
               else if (ob_hit || ob_free_ok)
               begin
                  wr_en = !ob_hit;
                  use_en = 1'b1;
                  use_idx = ob_hit ? ob_hit_idx : ob_free_idx;
                  close_en = hdr_ff.tcp_close && (hdr_ff.proto == PR_TCP);
                  nxt_pkt.act = ACT_FWD_OPER;
                  nxt_pkt.hdr.src.ip = cfg_pub_ip;
                  if (hdr_ff.icmp_err)
                     nxt_pkt.hdr.in_dst = '{ip: cfg_pub_ip, port: use_port};
                  else
                     nxt_pkt.hdr.src.port = use_port;
                  if (hdr_ff.ftp_sig && (hdr_ff.proto == PR_TCP) &&
                      npt_is_private(hdr_ff.ftp.ip))
                     nxt_st = ST_ALG;
               end
            end
            else if (ib_hit)
            begin
               use_en = 1'b1;
               use_idx = ib_idx;
               close_en = hdr_ff.tcp_close && (hdr_ff.proto == PR_TCP);
               nxt_pkt.act = ACT_FWD_CUST;
               nxt_pkt.hdr.dst.ip = ent_ff[ib_idx].ip;
               if (hdr_ff.icmp_err)
                  nxt_pkt.hdr.in_src = ent_ff[ib_idx];
               else
                  nxt_pkt.hdr.dst.port = ent_ff[ib_idx].port;
            end
            else if (hdr_ff.dst.ip == cfg_pub_ip)
               nxt_pkt.act = ACT_LOCAL;
         end
         ST_ALG:
         begin
            nxt_st = ST_SEND;
            if (ob_hit || ob_free_ok)
            begin
               wr_en = !ob_hit;
               use_en = 1'b1;
               use_idx = ob_hit ? ob_hit_idx : ob_free_idx;
               nxt_pkt.hdr.ftp = '{ip: cfg_pub_ip, port: use_port};
            end
            else
               nxt_pkt.act = ACT_DROP;
         end
         ST_SEND:
         begin
            if (out_ready)
               nxt_st = ST_IDLE;
         end
         default:
            nxt_st = ST_IDLE;
      endcase
   end

   // Public port is fixed by entry position, so a private pair keeps its
   // public pair for as long as its entry lives.
   always_comb
   begin
      use_port = PUB_PORT_BASE + 16'(use_idx);
      restart = '0;
      restart[use_idx] = use_en;
   end

   // ----------------------------------------------------------------
   // Stream handshake and sequencing
   // ----------------------------------------------------------------
   // Takes one header at a time and holds the result until drained.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= ST_IDLE;
         in_ready_ff <= 1'b0;
         out_valid_ff <= 1'b0;
         hdr_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
         in_ready_ff <= (nxt_st == ST_IDLE);
         out_valid_ff <= (nxt_st == ST_SEND);
         if (in_valid && in_ready_ff)
            hdr_ff <= in_hdr;
      end
   end

   // Result register feeding the output stream.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         pkt_ff <= '{act: ACT_DROP, hdr: '0};
      else
         pkt_ff <= nxt_pkt;
   end

   // Status flags.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_bad_ff <= 1'b0;
         tbl_full_ff <= 1'b0;
      end
      else
      begin
         cfg_bad_ff <= !npt_is_private(cfg_cust_ip);
         tbl_full_ff <= &ent_vld_ff;
      end
   end

   // ----------------------------------------------------------------
   // Translation table
   // ----------------------------------------------------------------
   // A write installs both directions; close or expiry frees an entry,
   // and a write in the same cycle wins over either.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ent_vld_ff <= '0;
         ent_ff <= '0;
      end
      else
      begin
         for (int i = 0; i < TBL_DEPTH; i++)
         begin
            if (wr_en && (use_idx == IW'(i)))
            begin
               ent_vld_ff[i] <= 1'b1;
               ent_ff[i] <= key;
            end
            else if ((close_en && (use_idx == IW'(i))) || expired[i])
               ent_vld_ff[i] <= 1'b0;
         end
      end
   end

   npt_age #(
      .N(TBL_DEPTH),
      .TICK_CYC(AGE_TICK_CYC),
      .TW(TMO_W)
   ) u_age (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .restart(restart),
      .timeout(tmo_sec),
      .expired(expired)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_out_main;
      (st_ff == ST_MAIN) && hdr_ff.from_oper && !is_igmp;
   endsequence

   sequence s_cust_main;
      (st_ff == ST_MAIN) && !hdr_ff.from_oper && !is_igmp && src_priv;
   endsequence

   cust_priv_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      1'b1 |=> (cfg_bad_ff == !npt_is_private($past(cfg_cust_ip))))
      else $error("customer address check wrong");

   no_leak_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (out_valid_ff && (pkt_ff.act == ACT_FWD_OPER)) |->
      (!npt_is_private(pkt_ff.hdr.dst.ip) && (pkt_ff.hdr.src.ip == cfg_pub_ip)))
      else $error("private address leaked to operator side");

   no_inb_create_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_out_main |=> ((ent_vld_ff & ~$past(ent_vld_ff)) == '0))
      else $error("inbound packet created an entry");

   lan_pass_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_cust_main ##0 dst_priv |=> (((ent_vld_ff & ~$past(ent_vld_ff)) == '0) &&
      out_valid_ff && (pkt_ff.act == ACT_FWD_CUST) && (pkt_ff.hdr == $past(hdr_ff))))
      else $error("customer to customer packet translated");

   create_both_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_cust_main ##0 (!dst_priv && !ob_hit && ob_free_ok) |=>
      ent_vld_ff[$past(ob_free_idx)] && (ent_ff[$past(ob_free_idx)] == $past(key)))
      else $error("entry not created on outbound miss");

   map_stable_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_cust_main ##0 (!dst_priv && ob_hit && !hdr_ff.icmp_err) |=>
      (pkt_ff.hdr.src.port == PUB_PORT_BASE + 16'($past(ob_hit_idx))))
      else $error("private pair mapped to a different public pair");

   rx_restore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_out_main ##0 (ib_hit && !hdr_ff.icmp_err) |=> out_valid_ff &&
      (pkt_ff.act == ACT_FWD_CUST) && (pkt_ff.hdr.dst == $past(ent_ff[ib_idx])))
      else $error("reply not restored to private pair");

   icmp_inner_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_cust_main ##0 (!dst_priv && hdr_ff.icmp_err && (ob_hit || ob_free_ok)) |=>
      (pkt_ff.hdr.in_dst.ip == cfg_pub_ip) && (pkt_ff.hdr.src.ip == cfg_pub_ip))
      else $error("embedded header not translated");

   ftp_sig_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      ((st_ff == ST_ALG) && (ob_hit || ob_free_ok)) |=>
      (pkt_ff.hdr.ftp.ip == cfg_pub_ip) && out_valid_ff)
      else $error("signalled data address not translated");

   igmp_local_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      ((st_ff == ST_MAIN) && is_igmp) |=> (pkt_ff.act == ACT_LOCAL) &&
      (pkt_ff.hdr == $past(hdr_ff)) && ((ent_vld_ff & ~$past(ent_vld_ff)) == '0))
      else $error("membership message was translated");

   use_restart_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_out_main ##0 ib_hit |-> restart[ib_idx])
      else $error("inbound use did not restart timer");

endmodule

`default_nettype wire

// file: testbench/npt_far_sink.sv
// Far-side model that accepts translated headers from the translator.
// Assumes results are offered on a valid/ready stream clocked by sys_clk.
`default_nettype none

module npt_far_sink (
   input wire logic sys_clk, // System clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic stall, // Slow acceptance when high.
   output logic out_ready // Result accepted when high.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_ff;

   // Counts a three-cycle pattern so a stalled sink accepts one cycle in three.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_ff <= 2'h0;
      end
      else
      begin
         cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      end
   end

   // Accepts every cycle unless told to stall.
   assign out_ready = !stall || (cnt_ff == 2'h2);
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the address and port translator.
// Assumes a short age tick and a four-entry table to keep the run brief.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import npt_pkg::*;
   localparam logic [31:0] PUB = 32'hC6336401;
   localparam logic [31:0] H5 = 32'h0A000005;
   localparam logic [31:0] REM = 32'h08080808;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic in_valid = 1'b0;
   logic stall = 1'b0;
   logic cfg_tmo_en = 1'b0;
   logic [15:0] cfg_tmo_sec = 16'h0003;
   logic [31:0] cfg_cust_ip = 32'h0A000001;
   logic in_ready, out_valid, out_ready, cfg_bad, tbl_full;
   npt_hdr_s in_hdr = '0;
   npt_hdr_s h, e, qin, qret;
   npt_out_s out_pkt, got;
   npt_hdr_s rin[$];
   npt_out_s rexp[$];
   bit rfull[$];
   int err_total = 0;
   int n_tests = 0;

   // Free-running 100 MHz clock.
   always #5 sys_clk = ~sys_clk;

   npt_translator #(.TBL_DEPTH(4), .AGE_TICK_CYC(10)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
      .in_valid(in_valid), .in_ready(in_ready), .in_hdr(in_hdr), .out_valid(out_valid),
      .out_ready(out_ready), .out_pkt(out_pkt), .cfg_pub_ip(PUB), .cfg_cust_ip(cfg_cust_ip),
      .cfg_tmo_en(cfg_tmo_en), .cfg_tmo_sec(cfg_tmo_sec), .cfg_bad(cfg_bad),
      .tbl_full(tbl_full));
   npt_far_sink u_sink (.sys_clk(sys_clk), .rstn(rstn), .stall(stall), .out_ready(out_ready));

   // Compares a seen value with the expected one and counts the result.
   task automatic chk(input string nm, input logic [$bits(npt_out_s)-1:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // Builds a plain header with all gateway fields cleared.
   function automatic npt_hdr_s mk(input logic o, input npt_proto_e p, input logic [31:0] si,
      input logic [15:0] sp, input logic [31:0] di, input logic [15:0] dp);
      mk = '0;
      mk.from_oper = o;
      mk.proto = p;
      mk.src = {si, sp};
      mk.dst = {di, dp};
   endfunction

   // Queues one table row; f clear means only the action is compared.
   task automatic row(input npt_hdr_s i, input npt_act_e a, input npt_hdr_s x, input bit f);
      rin.push_back(i);
      rexp.push_back({a, x});
      rfull.push_back(f);
   endtask

   // Offers one header, holds it until taken, then waits for the result.
   task automatic xfer(input npt_hdr_s hi, output npt_out_s o);
      int n = 0;
      @(posedge sys_clk);
      in_valid <= 1'b1;
      in_hdr <= hi;
      do @(posedge sys_clk); while (in_ready !== 1'b1 && ++n < 50);
      in_valid <= 1'b0;
      do @(posedge sys_clk); while ((out_valid & out_ready) !== 1'b1 && ++n < 90);
      o = out_pkt;
      if (n >= 90) chk("handshake", 1'b0, 1'b1);
   endtask

   // Sends one header and compares the whole result.
   task automatic sendc(input npt_hdr_s hi, input npt_act_e a, input npt_hdr_s x);
      xfer(hi, got);
      chk("result", got, {a, x});
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #50us;
      err_total++;
      report_and_stop();
   end

   // Main sequence: reset, table rows, then ageing, close and config cases.
   initial
   begin
      qin = mk(1'b1, PR_UDP, REM, 16'h0035, PUB, 16'hC000);
      qret = mk(1'b1, PR_UDP, REM, 16'h0035, H5, 16'h03E8);
      h = mk(1'b0, PR_UDP, H5, 16'h03E8, REM, 16'h0035);
      row(h, ACT_FWD_OPER, mk(1'b0, PR_UDP, PUB, 16'hC000, REM, 16'h0035), 1);
      h.dst.port = 16'h0050;
      row(h, ACT_FWD_OPER, mk(1'b0, PR_UDP, PUB, 16'hC000, REM, 16'h0050), 1);
      row(qin, ACT_FWD_CUST, qret, 1);
      h = mk(1'b1, PR_UDP, REM, 16'h0035, PUB, 16'hC003);
      row(h, ACT_LOCAL, h, 1);
      h = mk(1'b0, PR_UDP, H5, 16'h03E8, 32'hC0A80102, 16'h0050);
      row(h, ACT_FWD_CUST, h, 1);
      h = mk(1'b0, PR_IGMP, H5, 16'h0000, 32'hE0000016, 16'h0000);
      row(h, ACT_LOCAL, h, 1);
      row(mk(1'b0, PR_UDP, 32'h0B000001, 16'h0005, REM, 16'h0035), ACT_DROP, h, 0);
      row(qret, ACT_DROP, h, 0);
      h = mk(1'b0, PR_ICMP, H5, 16'h0000, REM, 16'h0000);
      h.icmp_err = 1'b1;
      h.in_src = {REM, 16'h0035};
      h.in_dst = {H5, 16'h03E8};
      e = h;
      e.src.ip = PUB;
      e.in_dst = {PUB, 16'hC000};
      row(h, ACT_FWD_OPER, e, 1);
      h = mk(1'b1, PR_ICMP, REM, 16'h0000, PUB, 16'h0000);
      h.icmp_err = 1'b1;
      h.in_src = {PUB, 16'hC000};
      h.in_dst = {REM, 16'h0035};
      e = h;
      e.dst.ip = H5;
      e.in_src = {H5, 16'h03E8};
      row(h, ACT_FWD_CUST, e, 1);
      h = mk(1'b0, PR_TCP, 32'h0A000007, 16'h0400, REM, 16'h0015);
      h.ftp_sig = 1'b1;
      h.ftp = {32'h0A000007, 16'h7530};
      e = h;
      e.src = {PUB, 16'hC001};
      e.ftp = {PUB, 16'hC002};
      row(h, ACT_FWD_OPER, e, 1);
      h = mk(1'b0, PR_UDP, 32'h0A000006, 16'h07D0, REM, 16'h0035);
      e = h;
      e.src = {PUB, 16'hC003};
      row(h, ACT_FWD_OPER, e, 1);
      row(mk(1'b0, PR_UDP, 32'h0A000008, 16'h0BB8, REM, 16'h0035), ACT_DROP, h, 0);
      repeat (19) @(posedge sys_clk);
      chk("reset_state", {in_ready, out_valid, cfg_bad, tbl_full}, 4'h0);
      @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (rin[i])
      begin
         stall <= i[0];
         xfer(rin[i], got);
         if (rfull[i])
            chk("row", got, rexp[i]);
         else
            chk("row_act", got.act, rexp[i].act);
      end
      chk("table_full", tbl_full, 1'b1);
      stall <= 1'b0;
      cfg_tmo_en <= 1'b1;
      repeat (80) @(posedge sys_clk);
      chk("table_empty", tbl_full, 1'b0);
      sendc(qin, ACT_LOCAL, qin);
      h = mk(1'b0, PR_UDP, H5, 16'h03E8, REM, 16'h0035);
      sendc(h, ACT_FWD_OPER, mk(1'b0, PR_UDP, PUB, 16'hC000, REM, 16'h0035));
      repeat (4)
      begin
         repeat (8) @(posedge sys_clk);
         sendc(qin, ACT_FWD_CUST, qret);
      end
      repeat (40) @(posedge sys_clk);
      sendc(qin, ACT_LOCAL, qin);
      // A creating packet keeps its entry, so the close rides on a later hit.
      h = mk(1'b0, PR_TCP, H5, 16'h03E8, REM, 16'h0050);
      e = h;
      e.src = {PUB, 16'hC000};
      sendc(h, ACT_FWD_OPER, e);
      h.tcp_close = 1'b1;
      e.tcp_close = 1'b1;
      sendc(h, ACT_FWD_OPER, e);
      h = mk(1'b1, PR_TCP, REM, 16'h0050, PUB, 16'hC000);
      sendc(h, ACT_LOCAL, h);
      cfg_cust_ip <= 32'h0B000001;
      repeat (3) @(posedge sys_clk);
      chk("cfg_bad_set", cfg_bad, 1'b1);
      cfg_cust_ip <= 32'h0A000001;
      repeat (3) @(posedge sys_clk);
      chk("cfg_bad_clear", cfg_bad, 1'b0);
      report_and_stop();
   end
endmodule

`default_nettype wire
